// ===== core/dpm_pkg.sv
package dpm_pkg;

  // ****************************************
  // register map (indices; byte address = 4 * index)
  // ****************************************
  localparam logic [9:0] IDX_CTRL   = 10'h018;
  localparam logic [9:0] IDX_STS    = 10'h019;
  localparam logic [9:0] IDX_BUF_LO = 10'h0DE;
  localparam logic [9:0] IDX_BUF_HI = 10'h135;
  localparam int         BUF_DEPTH  = 88;
  localparam int         AXI_AW     = 12;

  // ****************************************
  // control and status fields
  // ****************************************
  localparam int CTL_IRQ_FLAG  = 0;
  localparam int CTL_IRQ_MASK  = 1;
  localparam int CTL_RX_ON     = 2;
  localparam int STS_FLAG      = 0;
  localparam int STS_DONE      = 1;
  localparam int STS_MISMATCH  = 2;
  localparam int STS_CR        = 3;
  localparam int STS_KIND_LO   = 4;
  localparam int STS_ABORT     = 6;
  localparam logic CTL_RX_ON_RST   = 1'b0;
  localparam logic CTL_IRQ_MASK_RST = 1'b0;

  // ****************************************
  // framing constants
  // ****************************************
  localparam logic [7:0]  FLAG_OCT     = 8'h7E;
  localparam logic [15:0] CRC_INIT     = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REV = 16'h8408;
  localparam logic [2:0]  ONES_STUFF   = 3'h5;
  localparam logic [2:0]  ONES_ABORT   = 3'h6;
  localparam logic [6:0]  HDR_OCTS     = 7'h03;
  localparam logic [6:0]  KIND_POS     = 7'h03;
  localparam int          CR_BIT       = 1;
  localparam logic [7:0]  TYPE_TEST    = 8'h32;
  localparam logic [7:0]  TYPE_IDLE    = 8'h34;
  localparam logic [7:0]  TYPE_PATH    = 8'h38;
  localparam logic [7:0]  TYPE_PATH82  = 8'h3F;
  localparam logic [1:0]  KIND_TEST    = 2'h0;
  localparam logic [1:0]  KIND_IDLE    = 2'h1;
  localparam logic [1:0]  KIND_PATH    = 2'h2;
  localparam logic [1:0]  KIND_PATH82  = 2'h3;

  // ****************************************
  // bus answers and decode
  // ****************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {RG_CTRL, RG_STS, RG_BUF, RG_NONE} dpm_region_e;

  function automatic dpm_region_e dpm_decode(input logic [AXI_AW-1:0] addr);
    logic [9:0] idx;
    idx = addr[AXI_AW-1:2];
    if (idx == IDX_CTRL) begin
      return RG_CTRL;
    end else if (idx == IDX_STS) begin
      return RG_STS;
    end else if (idx >= IDX_BUF_LO && idx <= IDX_BUF_HI) begin
      return RG_BUF;
    end
    return RG_NONE;
  endfunction : dpm_decode

endpackage : dpm_pkg

// ===== core/dpm_buf_if.sv
`timescale 1ns/10ps
interface dpm_buf_if;
  logic       we;
  logic [6:0] waddr;
  logic [7:0] wdata;
  logic [6:0] raddr;
  logic [7:0] rdata;
  modport fill  (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : dpm_buf_if

// ===== core/dpm_msg_ram.sv
`timescale 1ns/10ps
module dpm_msg_ram (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // buffer port
  dpm_buf_if.store  buf_p
);

  logic [7:0] mem [dpm_pkg::BUF_DEPTH];
  logic [7:0] rdata_q;

  // ****************************************
  // storage and registered read
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (ce_i && buf_p.we) begin
      mem[buf_p.waddr] <= buf_p.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      rdata_q <= (32'(buf_p.raddr) < dpm_pkg::BUF_DEPTH) ? mem[buf_p.raddr] : 8'h00;
    end
  end

  assign buf_p.rdata = rdata_q;

endmodule : dpm_msg_ram

// ===== core/dpm_msg_rx.sv
`timescale 1ns/10ps
// Behaviour
// - take message bits only on the data-link strobe, as one serial stream.
// - store information octets into buffer indices 0xDE through 0x135.
// - frames are delimited by 0x7E flags; repeated idle flags allowed.
// - 16-bit check word, high octet first, generator x16+x12+x5+1.
// - receiver idle until control bit 2 set; setting it starts flag hunt.
// - a detected flag sets status bit 0.
// - any non-flag octet clears status bit 0; closing flag sets it again.
// - seven or more ones after a flag set abort, status bit 6.
// - status bit 3 mirrors command/response bit of first address octet.
// - status bits 5:4 encode message type from leading information octet.
// - closing flag sets end-of-message, status bit 1.
// - interrupt at end only if message differs; flag ctrl bit 0, mask bit 1.
// - check match clears status bit 2; mismatch sets it.
// - a check error never raises the interrupt.
// - stuffed zeros removed before storing and check computation.
// - a zero right after five ones is discarded.
module dpm_msg_rx (
  // clock, reset, enable
  input  wire logic        MCLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        CE_I,
  // data-link bits from the framer
  input  wire logic        LINK_BIT_I,
  input  wire logic        LINK_STB_I,
  // axi4-lite write
  input  wire logic [11:0] S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  // axi4-lite read
  input  wire logic [11:0] S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  // message interrupt
  output logic             IRQ_O
);

  typedef enum logic [1:0] {ST_HUNT, ST_FLAG, ST_FRAME} dpm_rx_state_e;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I || !CE_I);

  dpm_buf_if buf_p ();

  dpm_msg_ram u_ram (
    .clk_i   (MCLK_I),
    .rst_n_i (RST_N_I),
    .ce_i    (CE_I),
    .buf_p   (buf_p.store)
  );

  dpm_rx_state_e st_q;
  logic          on_q, mask_q, irq_q;
  logic [2:0]    ones_q;
  logic [7:0]    raw_q, dat_q, h0_q, h1_q;
  logic [3:0]    dcnt_q;
  logic [1:0]    hcnt_q;
  logic [6:0]    k_q, prev_k_q;
  logic [15:0]   crc_q, prev_chk_q;
  logic          prev_ok_q;
  logic          s_flag_q, s_done_q, s_mis_q, s_cr_q, s_abort_q;
  logic [1:0]    s_kind_q;

  // ****************************************
  // bit-level framing
  // ****************************************
  logic       bit_stb, flag_det, abort_det, stuffed, dat_bit, oct_stb, pop_stb;
  logic       close_evt, close_bad, differ, new_frame;
  logic [7:0] raw_n, dat_n;
  logic [15:0] rx_chk;

  assign bit_stb   = CE_I && LINK_STB_I && on_q;
  assign raw_n     = {LINK_BIT_I, raw_q[7:1]};
  assign flag_det  = bit_stb && (raw_n == dpm_pkg::FLAG_OCT);
  assign abort_det = bit_stb && LINK_BIT_I && (ones_q == dpm_pkg::ONES_ABORT)
                     && (st_q != ST_HUNT);
  assign stuffed   = !LINK_BIT_I && (ones_q == dpm_pkg::ONES_STUFF);
  assign dat_bit   = bit_stb && !stuffed && !flag_det && !abort_det
                     && (st_q != ST_HUNT);
  assign dat_n     = {LINK_BIT_I, dat_q[7:1]};
  assign oct_stb   = dat_bit && (dcnt_q == 4'h7);
  assign new_frame = oct_stb && (st_q == ST_FLAG);
  assign pop_stb   = oct_stb && (hcnt_q == 2'h2);
  assign close_evt = flag_det && (st_q == ST_FRAME);
  assign rx_chk    = {h0_q, h1_q};
  assign close_bad = (hcnt_q != 2'h2) || (~crc_q != rx_chk);
  assign differ    = !prev_ok_q || (rx_chk != prev_chk_q) || (k_q != prev_k_q);

  function automatic logic [15:0] crc_octet(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ dpm_pkg::CRC_POLY_REV) : (r >> 1);
    end
    return r;
  endfunction : crc_octet

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ones_q <= 3'h0;
      raw_q  <= 8'h00;
    end else if (bit_stb) begin
      raw_q  <= raw_n;
      ones_q <= !LINK_BIT_I ? 3'h0 : ((ones_q == 3'h7) ? ones_q : ones_q + 3'h1);
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_q <= ST_HUNT;
    end else if (CE_I) begin
      if (!on_q) begin
        st_q <= ST_HUNT;
      end else if (abort_det) begin
        st_q <= ST_HUNT;
      end else if (flag_det) begin
        st_q <= ST_FLAG;
      end else if (oct_stb) begin
        st_q <= ST_FRAME;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dat_q  <= 8'h00;
      dcnt_q <= 4'h0;
    end else if (flag_det) begin
      dcnt_q <= 4'h0;
    end else if (dat_bit) begin
      dat_q  <= dat_n;
      dcnt_q <= oct_stb ? 4'h0 : dcnt_q + 4'h1;
    end
  end

  sequence s_stuffed;
    bit_stb && !LINK_BIT_I && (ones_q == dpm_pkg::ONES_STUFF);
  endsequence
  AST_STUFF_DROPPED: assert property (s_stuffed |=> $stable(dat_q))
    else $error("stuffed zero entered the data path");

  // ****************************************
  // octet delay, check word and buffer fill
  // ****************************************
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      h0_q   <= 8'h00;
      h1_q   <= 8'h00;
      hcnt_q <= 2'h0;
      k_q    <= 7'h00;
      crc_q  <= dpm_pkg::CRC_INIT;
    end else if (CE_I) begin
      if (flag_det || abort_det) begin
        hcnt_q <= 2'h0;
        k_q    <= 7'h00;
        crc_q  <= dpm_pkg::CRC_INIT;
      end else if (oct_stb) begin
        if (hcnt_q == 2'h2) begin
          h0_q  <= h1_q;
          h1_q  <= dat_n;
          crc_q <= crc_octet(crc_q, h0_q);
          k_q   <= (k_q == 7'h7F) ? k_q : k_q + 7'h01;
        end else begin
          hcnt_q <= hcnt_q + 2'h1;
          if (hcnt_q == 2'h0) begin
            h0_q <= dat_n;
          end else begin
            h1_q <= dat_n;
          end
        end
      end
    end
  end

  logic [6:0] info_idx;
  assign info_idx    = k_q - dpm_pkg::HDR_OCTS;
  assign buf_p.we    = pop_stb && (k_q >= dpm_pkg::HDR_OCTS)
                       && (32'(info_idx) < dpm_pkg::BUF_DEPTH);
  assign buf_p.waddr = info_idx;
  assign buf_p.wdata = h0_q;

  AST_BUF_IN_RANGE: assert property (buf_p.we |-> 32'(buf_p.waddr) < dpm_pkg::BUF_DEPTH)
    else $error("buffer write outside message area");

  // ****************************************
  // status register
  // ****************************************
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_flag_q <= 1'b0;
    end else if (flag_det) begin
      s_flag_q <= 1'b1;
    end else if (oct_stb || abort_det) begin
      s_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_done_q  <= 1'b0;
      s_mis_q   <= 1'b0;
      s_abort_q <= 1'b0;
    end else if (CE_I) begin
      if (close_evt) begin
        s_done_q <= 1'b1;
        s_mis_q  <= close_bad;
      end else if (new_frame) begin
        s_done_q <= 1'b0;
      end
      if (abort_det) begin
        s_abort_q <= 1'b1;
      end else if (new_frame) begin
        s_abort_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_cr_q   <= 1'b0;
      s_kind_q <= dpm_pkg::KIND_TEST;
    end else if (pop_stb) begin
      if (k_q == 7'h00) begin
        s_cr_q <= h0_q[dpm_pkg::CR_BIT];
      end
      if (k_q == dpm_pkg::KIND_POS) begin
        unique case (h0_q)
          dpm_pkg::TYPE_IDLE:   s_kind_q <= dpm_pkg::KIND_IDLE;
          dpm_pkg::TYPE_PATH:   s_kind_q <= dpm_pkg::KIND_PATH;
          dpm_pkg::TYPE_PATH82: s_kind_q <= dpm_pkg::KIND_PATH82;
          default:              s_kind_q <= dpm_pkg::KIND_TEST;
        endcase
      end
    end
  end

  AST_FLAG_SETS: assert property (flag_det |=> s_flag_q)
    else $error("flag present not set after flag");
  AST_NONFLAG_CLEARS: assert property (oct_stb |=> !s_flag_q)
    else $error("flag present not cleared by data octet");
  AST_ABORT_SETS: assert property (abort_det |=> s_abort_q && st_q == ST_HUNT)
    else $error("abort not reported or hunt not resumed");
  AST_DONE_ON_CLOSE: assert property (close_evt |=> s_done_q && s_flag_q)
    else $error("end of message not set at closing flag");
  AST_OFF_IDLE: assert property (!on_q |-> !oct_stb && !flag_det)
    else $error("receiver active while disabled");

  // ****************************************
  // message interrupt
  // ****************************************
  logic irq_set, irq_clr;
  assign irq_set = close_evt && !close_bad && differ;

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      prev_ok_q  <= 1'b0;
      prev_chk_q <= 16'h0000;
      prev_k_q   <= 7'h00;
    end else if (close_evt && !close_bad) begin
      prev_ok_q  <= 1'b1;
      prev_chk_q <= rx_chk;
      prev_k_q   <= k_q;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_q <= 1'b0;
    end else if (CE_I) begin
      if (irq_set) begin
        irq_q <= 1'b1;
      end else if (irq_clr) begin
        irq_q <= 1'b0;
      end
    end
  end

  assign IRQ_O = irq_q && mask_q;

  sequence s_bad_close;
    close_evt && close_bad;
  endsequence
  AST_NO_IRQ_ON_ERR: assert property (s_bad_close |=> !$rose(irq_q))
    else $error("interrupt raised by check error");
  AST_IRQ_CAUSE: assert property ($rose(irq_q) |-> $past(irq_set))
    else $error("interrupt flag rose without a new message");

  // ****************************************
  // axi4-lite write
  // ****************************************
  logic                 aw_have_q, w_have_q, bvalid_q, do_wr;
  logic [11:0]          awaddr_q;
  logic [31:0]          wdata_q;
  logic                 wstrb0_q;
  logic [1:0]           bresp_q;
  dpm_pkg::dpm_region_e wr_rg;

  assign S_AXI_AWREADY_O = !aw_have_q && !bvalid_q;
  assign S_AXI_WREADY_O  = !w_have_q && !bvalid_q;
  assign do_wr           = CE_I && aw_have_q && w_have_q;
  assign wr_rg           = dpm_pkg::dpm_decode(awaddr_q);

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb0_q  <= 1'b0;
    end else if (CE_I) begin
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end else begin
        if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
          aw_have_q <= 1'b1;
          awaddr_q  <= S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
          w_have_q <= 1'b1;
          wdata_q  <= S_AXI_WDATA_I;
          wstrb0_q <= S_AXI_WSTRB_I[0];
        end
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      bvalid_q <= 1'b0;
      bresp_q  <= dpm_pkg::RESP_OKAY;
    end else if (CE_I) begin
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_rg == dpm_pkg::RG_NONE) ? dpm_pkg::RESP_SLVERR : dpm_pkg::RESP_OKAY;
      end else if (S_AXI_BREADY_I) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      on_q   <= dpm_pkg::CTL_RX_ON_RST;
      mask_q <= dpm_pkg::CTL_IRQ_MASK_RST;
    end else if (do_wr && wr_rg == dpm_pkg::RG_CTRL && wstrb0_q) begin
      on_q   <= wdata_q[dpm_pkg::CTL_RX_ON];
      mask_q <= wdata_q[dpm_pkg::CTL_IRQ_MASK];
    end
  end

  assign S_AXI_BVALID_O = bvalid_q;
  assign S_AXI_BRESP_O  = bresp_q;

  AST_WRITE_ANSWERED: assert property (do_wr |=> S_AXI_BVALID_O)
    else $error("write response missing");

  // ****************************************
  // axi4-lite read
  // ****************************************
  logic                 rd_pend_q, rvalid_q, ar_hs;
  logic [31:0]          rdata_q;
  logic [1:0]           rresp_q;
  dpm_pkg::dpm_region_e rd_rg_q;
  logic [9:0]           ar_idx;

  assign S_AXI_ARREADY_O = !rd_pend_q && !rvalid_q;
  assign ar_hs           = CE_I && S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  assign ar_idx          = S_AXI_ARADDR_I[11:2] - dpm_pkg::IDX_BUF_LO;
  assign buf_p.raddr     = ar_idx[6:0];
  assign irq_clr         = rd_pend_q && rd_rg_q == dpm_pkg::RG_CTRL;

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rd_pend_q <= 1'b0;
      rd_rg_q   <= dpm_pkg::RG_NONE;
    end else if (CE_I) begin
      rd_pend_q <= ar_hs;
      if (ar_hs) begin
        rd_rg_q <= dpm_pkg::dpm_decode(S_AXI_ARADDR_I);
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= dpm_pkg::RESP_OKAY;
    end else if (CE_I) begin
      if (rd_pend_q) begin
        rvalid_q <= 1'b1;
        rresp_q  <= dpm_pkg::RESP_OKAY;
        unique case (rd_rg_q)
          dpm_pkg::RG_CTRL: rdata_q <= {29'h0, on_q, mask_q, irq_q};
          dpm_pkg::RG_STS:  rdata_q <= {25'h0, s_abort_q, s_kind_q, s_cr_q,
                                        s_mis_q, s_done_q, s_flag_q};
          dpm_pkg::RG_BUF:  rdata_q <= {24'h0, buf_p.rdata};
          dpm_pkg::RG_NONE: begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= dpm_pkg::RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RREADY_I) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign S_AXI_RVALID_O = rvalid_q;
  assign S_AXI_RDATA_O  = rdata_q;
  assign S_AXI_RRESP_O  = rresp_q;

  AST_READ_LATENCY: assert property (ar_hs |-> ##2 S_AXI_RVALID_O)
    else $error("read answer not two cycles after address");

endmodule : dpm_msg_rx

// ===== verif/dpm_far_tx.sv
`timescale 1ns/10ps
module dpm_far_tx (
  // clock
  input  wire logic clk_i,
  // data-link bits
  output logic      link_bit_o,
  output logic      link_stb_o
);
  int          ones = 0;
  int          gap  = 1;
  logic [15:0] crc  = 16'hFFFF;

  initial begin
    link_bit_o = 1'b0;
    link_stb_o = 1'b0;
  end

  // idle line shows the inverse of the last bit
  task automatic put_bit(input logic b);
    @(posedge clk_i);
    link_bit_o <= b;
    link_stb_o <= 1'b1;
    @(posedge clk_i);
    link_bit_o <= ~b;
    link_stb_o <= 1'b0;
    repeat (gap - 1) @(posedge clk_i);
  endtask : put_bit

  task automatic put_oct(input logic [7:0] o, input bit stuff, input bit sum);
    for (int i = 0; i < 8; i++) begin
      put_bit(o[i]);
      if (sum) crc = (crc[0] ^ o[i]) ? (crc >> 1) ^ 16'h8408 : crc >> 1;
      ones = o[i] ? ones + 1 : 0;
      if (stuff && ones == 5) begin
        put_bit(1'b0);
        ones = 0;
      end
    end
    if (!stuff) ones = 0;
  endtask : put_oct

  task automatic send_frame(input logic [7:0] a1, input logic [7:0] info[$], input bit bad,
                            input int g);
    logic [15:0] chk;
    gap = g;
    crc = 16'hFFFF;
    put_oct(8'h7E, 1'b0, 1'b0);
    put_oct(a1, 1'b1, 1'b1);
    put_oct(8'h01, 1'b1, 1'b1);
    put_oct(8'h03, 1'b1, 1'b1);
    foreach (info[i]) put_oct(info[i], 1'b1, 1'b1);
    chk = ~crc ^ {15'h0, bad};
    put_oct(chk[15:8], 1'b1, 1'b0);
    put_oct(chk[7:0], 1'b1, 1'b0);
    put_oct(8'h7E, 1'b0, 1'b0);
  endtask : send_frame
endmodule : dpm_far_tx

// ===== verif/dpm_msg_rx_tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("Error %0t: got %h exp %h", $time, (g), (e)); \
  end \
end
module dpm_msg_rx_tb_top;
  localparam logic [11:0] A_CTRL = 12'h060;
  localparam logic [11:0] A_STS  = 12'h064;
  localparam logic [1:0]  OK     = 2'h0;
  logic        mclk    = 1'b0;
  logic        rst_n   = 1'b0;
  logic        ce      = 1'b1;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [11:0] awaddr  = 12'h000;
  logic [11:0] araddr  = 12'h000;
  logic [31:0] wdata   = 32'h0000_0000;
  logic        awready, wready, bvalid, arready, rvalid, irq, link_bit, link_stb;
  logic [1:0]  bresp, rresp, wr_resp;
  logic [31:0] rdata;
  int          bad_count = 0;
  int          n_tests   = 0;

  initial begin
    forever #10 mclk = ~mclk;
  end

  dpm_msg_rx i_dpm_msg_rx (
    .MCLK_I(mclk), .RST_N_I(rst_n), .CE_I(ce), .LINK_BIT_I(link_bit), .LINK_STB_I(link_stb),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .IRQ_O(irq));

  dpm_far_tx i_dpm_far_tx (.clk_i(mclk), .link_bit_o(link_bit), .link_stb_o(link_stb));

  // ****************************************
  // report and bus tasks
  // ****************************************
  task automatic complete_run();
    $display("Comparisons %0d, errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic fail_out();
    $display("Error %0t: handshake timeout", $time);
    bad_count++;
    complete_run();
  endtask : fail_out

  // ready sampled mid-cycle, released after the next rising edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    int   k;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(negedge mclk);
      aw_ok = awvalid & awready;
      w_ok  = wvalid & wready;
      b_ok  = bvalid;
      wr_resp = bresp;
      @(posedge mclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok) begin
        bready <= 1'b0;
        break;
      end
    end
    if (k == 100) fail_out();
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok, r_ok;
    int   k;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(negedge mclk);
      ar_ok = arvalid & arready;
      r_ok  = rvalid;
      d     = rdata;
      r     = rresp;
      @(posedge mclk);
      if (ar_ok) arvalid <= 1'b0;
      if (r_ok) begin
        rready <= 1'b0;
        break;
      end
    end
    if (k == 100) fail_out();
  endtask : axi_rd

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    `CHK(d, e)
    `CHK(r, er)
  endtask : rd_chk

  function automatic logic [1:0] exp_kind(input logic [7:0] t);
    case (t)
      8'h34:   return 2'h1;
      8'h38:   return 2'h2;
      8'h3F:   return 2'h3;
      default: return 2'h0;
    endcase
  endfunction : exp_kind

  // ****************************************
  // scenarios
  // ****************************************
  task automatic frame(input logic [7:0] t, input logic [7:0] a1, input bit bad, input int g,
                       input logic flg, input logic mask);
    logic [7:0] info[$];
    int         n;
    n = (t == 8'h3F) ? 82 : 76;
    for (int j = 0; j < n; j++) begin
      info.push_back((j == 0) ? t : (j == 1) ? 8'h7E : (j == 2) ? 8'hFF : 8'(t + j));
    end
    i_dpm_far_tx.send_frame(a1, info, bad, g);
    repeat (4) @(posedge mclk);
    `CHK(irq, flg & mask)
    rd_chk(A_STS, {26'h0, exp_kind(t), a1[1], bad, 2'b11}, OK);
    for (int j = 0; j < n; j++) begin
      rd_chk({10'h0DE + 10'(j), 2'b00}, {24'h0, info[j]}, OK);
    end
    rd_chk(A_CTRL, {29'h0, 1'b1, mask, flg}, OK);
    `CHK(irq, 1'b0)
  endtask : frame

  task automatic sc_regs();
    rd_chk(A_CTRL, 32'h0000_0000, OK);
    rd_chk(A_STS, 32'h0000_0000, OK);
    axi_wr(A_STS, 32'h0000_00FF);
    `CHK(wr_resp, OK)
    rd_chk(A_STS, 32'h0000_0000, OK);
    axi_wr(12'h000, 32'h0000_0001);
    `CHK(wr_resp, 2'h2)
    rd_chk(12'h000, 32'h0000_0000, 2'h2);
  endtask : sc_regs

  task automatic sc_enable();
    repeat (2) i_dpm_far_tx.put_oct(8'h7E, 1'b0, 1'b0);
    rd_chk(A_STS, 32'h0000_0000, OK);
    axi_wr(A_CTRL, 32'h0000_0004);
    `CHK(wr_resp, OK)
    // bits offered while the enable is low must be lost
    ce <= 1'b0;
    i_dpm_far_tx.put_oct(8'h7E, 1'b0, 1'b0);
    ce <= 1'b1;
    rd_chk(A_STS, 32'h0000_0000, OK);
    i_dpm_far_tx.put_oct(8'h7E, 1'b0, 1'b0);
    repeat (3) @(posedge mclk);
    rd_chk(A_STS, 32'h0000_0001, OK);
  endtask : sc_enable

  task automatic sc_types();
    logic [7:0] ty[4] = '{8'h32, 8'h34, 8'h38, 8'h3F};
    for (int i = 0; i < 4; i++) begin
      axi_wr(A_CTRL, {29'h0, 1'b1, (i != 0), 1'b0});
      frame(ty[i], i[0] ? 8'h3E : 8'h3C, 1'b0, i + 1, 1'b1, i != 0);
    end
  endtask : sc_types

  task automatic sc_abort();
    logic [31:0] d;
    logic [1:0]  r;
    i_dpm_far_tx.put_oct(8'h7E, 1'b0, 1'b0);
    i_dpm_far_tx.put_oct(8'h3C, 1'b1, 1'b0);
    i_dpm_far_tx.put_oct(8'h01, 1'b1, 1'b0);
    repeat (4) @(posedge mclk);
    axi_rd(A_STS, d, r);
    `CHK(d[0], 1'b0)
    repeat (8) i_dpm_far_tx.put_bit(1'b1);
    repeat (4) @(posedge mclk);
    axi_rd(A_STS, d, r);
    `CHK({d[6], d[1]}, 2'b10)
    `CHK(irq, 1'b0)
    frame(8'h34, 8'h3C, 1'b0, 1, 1'b1, 1'b1);
  endtask : sc_abort

  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    sc_regs();
    sc_enable();
    sc_types();
    frame(8'h3F, 8'h3E, 1'b0, 1, 1'b0, 1'b1);
    frame(8'h32, 8'h3C, 1'b1, 2, 1'b0, 1'b1);
    sc_abort();
    complete_run();
  end
endmodule : dpm_msg_rx_tb_top
